// ### rtl/iagc_regs.v
// input amplifier gain control register bank with gain ramps
`timescale 1ns/10ps
`include "iagc_consts.vh"

module iagc_regs
#(
	parameter [`IAGC_CNT_W-1:0] RAMP_FAST_CYC =
		`IAGC_STEP_FAST_CYC,
	parameter [`IAGC_CNT_W-1:0] RAMP_MID_CYC =
		`IAGC_STEP_MID_CYC,
	parameter [`IAGC_CNT_W-1:0] RAMP_SLOW_CYC =
		`IAGC_STEP_SLOW_CYC
)
(
	input wire sys_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	output reg [3:0] amp_mic_select,
	output reg [3:0] amp_power_up,
	output reg [3:0] amp_mute,
	output reg [3:0] amp_extra_gain,
	output reg [3:0] gain_ramp_disable,
	output wire [23:0] amp_gain_code,
	output wire [3:0] amp_ramp_busy
);

reg [7:0] ctl_reg [0:3];
reg [7:0] slew_reg;
reg [7:0] boost_reg;
reg [7:0] rdata_next;
reg hit_ctl;
reg hit_slew;
reg hit_boost;
reg [1:0] ctl_idx;
reg [`IAGC_CNT_W-1:0] step_cyc;
wire [3:0] ramp_on;
wire [3:0] ramp_hold;

// address decode
always @*
begin
	hit_ctl = 1'b0;
	hit_slew = 1'b0;
	hit_boost = 1'b0;
	ctl_idx = 2'h0;
	case (reg_addr)
		`IAGC_ADDR_AMP0:
		begin
			hit_ctl = 1'b1;
			ctl_idx = 2'h0;
		end
		`IAGC_ADDR_AMP1:
		begin
			hit_ctl = 1'b1;
			ctl_idx = 2'h1;
		end
		`IAGC_ADDR_AMP2:
		begin
			hit_ctl = 1'b1;
			ctl_idx = 2'h2;
		end
		`IAGC_ADDR_AMP3:
		begin
			hit_ctl = 1'b1;
			ctl_idx = 2'h3;
		end
		`IAGC_ADDR_SLEW: hit_slew = 1'b1;
		`IAGC_ADDR_BOOST: hit_boost = 1'b1;
		default: ctl_idx = 2'h0;
	endcase
end

// register writes
always @(posedge sys_clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		ctl_reg[0] <= `IAGC_AMP_RST;
		ctl_reg[1] <= `IAGC_AMP_RST;
		ctl_reg[2] <= `IAGC_AMP_RST;
		ctl_reg[3] <= `IAGC_AMP_RST;
		slew_reg <= `IAGC_SLEW_RST;
		boost_reg <= `IAGC_BOOST_RST;
	end
	else if (reg_wr)
	begin
		if (hit_ctl)
			ctl_reg[ctl_idx] <= reg_wdata;
		else if (hit_slew)
			slew_reg <= reg_wdata;
		else if (hit_boost)
			boost_reg <= reg_wdata;
	end
end

// read mux, unmapped addresses read zero
always @*
begin
	rdata_next = 8'h00;
	if (hit_ctl)
		rdata_next = ctl_reg[ctl_idx];
	else if (hit_slew)
		rdata_next = slew_reg;
	else if (hit_boost)
		rdata_next = boost_reg;
end

always @(posedge sys_clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		reg_rdata <= 8'h00;
		reg_rvalid <= 1'b0;
	end
	else
	begin
		reg_rvalid <= reg_rd;
		if (reg_rd)
			reg_rdata <= rdata_next;
	end
end

// shared step period from the rate field
always @*
begin
	case (slew_reg[`IAGC_RATE_HI:`IAGC_RATE_LO])
		`IAGC_RATE_FAST: step_cyc = RAMP_FAST_CYC;
		`IAGC_RATE_MID: step_cyc = RAMP_MID_CYC;
		`IAGC_RATE_SLOW: step_cyc = RAMP_SLOW_CYC;
		`IAGC_RATE_RSVD: step_cyc = RAMP_FAST_CYC;
		default: step_cyc = RAMP_FAST_CYC;
	endcase
end

// amplifier control outputs
always @(posedge sys_clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		amp_mic_select <= 4'h0;
		amp_power_up <= 4'h0;
		amp_mute <= 4'hf;
		amp_extra_gain <= 4'h0;
		gain_ramp_disable <= 4'h0;
	end
	else
	begin
		amp_mic_select[0] <= ctl_reg[0][`IAGC_MIC_BIT];
		amp_mic_select[1] <= ctl_reg[1][`IAGC_MIC_BIT];
		amp_mic_select[2] <= ctl_reg[2][`IAGC_MIC_BIT];
		amp_mic_select[3] <= ctl_reg[3][`IAGC_MIC_BIT];
		amp_power_up[0] <= ctl_reg[0][`IAGC_MIC_BIT];
		amp_power_up[1] <= ctl_reg[1][`IAGC_MIC_BIT];
		amp_power_up[2] <= ctl_reg[2][`IAGC_MIC_BIT];
		amp_power_up[3] <= ctl_reg[3][`IAGC_MIC_BIT];
		amp_mute[0] <= ctl_reg[0][`IAGC_MUTE_BIT];
		amp_mute[1] <= ctl_reg[1][`IAGC_MUTE_BIT];
		amp_mute[2] <= ctl_reg[2][`IAGC_MUTE_BIT];
		amp_mute[3] <= ctl_reg[3][`IAGC_MUTE_BIT];
		amp_extra_gain <= boost_reg[`IAGC_BOOST_HI:`IAGC_BOOST_LO];
		gain_ramp_disable <= slew_reg[`IAGC_RDIS_HI:`IAGC_RDIS_LO];
	end
end

// slew only while powered up and not disabled; mute freezes the code
assign ramp_on[0] = ctl_reg[0][`IAGC_MIC_BIT] & ~slew_reg[0];
assign ramp_on[1] = ctl_reg[1][`IAGC_MIC_BIT] & ~slew_reg[1];
assign ramp_on[2] = ctl_reg[2][`IAGC_MIC_BIT] & ~slew_reg[2];
assign ramp_on[3] = ctl_reg[3][`IAGC_MIC_BIT] & ~slew_reg[3];
assign ramp_hold[0] = ctl_reg[0][`IAGC_MUTE_BIT];
assign ramp_hold[1] = ctl_reg[1][`IAGC_MUTE_BIT];
assign ramp_hold[2] = ctl_reg[2][`IAGC_MUTE_BIT];
assign ramp_hold[3] = ctl_reg[3][`IAGC_MUTE_BIT];

// one ramp per amplifier
iagc_ramp u_ramp0
(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.target_code(ctl_reg[0][`IAGC_GAIN_HI:`IAGC_GAIN_LO]),
	.slew_on(ramp_on[0]),
	.hold(ramp_hold[0]),
	.step_cycles(step_cyc),
	.gain_reg(amp_gain_code[5:0]),
	.busy_reg(amp_ramp_busy[0])
);

iagc_ramp u_ramp1
(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.target_code(ctl_reg[1][`IAGC_GAIN_HI:`IAGC_GAIN_LO]),
	.slew_on(ramp_on[1]),
	.hold(ramp_hold[1]),
	.step_cycles(step_cyc),
	.gain_reg(amp_gain_code[11:6]),
	.busy_reg(amp_ramp_busy[1])
);

iagc_ramp u_ramp2
(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.target_code(ctl_reg[2][`IAGC_GAIN_HI:`IAGC_GAIN_LO]),
	.slew_on(ramp_on[2]),
	.hold(ramp_hold[2]),
	.step_cycles(step_cyc),
	.gain_reg(amp_gain_code[17:12]),
	.busy_reg(amp_ramp_busy[2])
);

iagc_ramp u_ramp3
(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.target_code(ctl_reg[3][`IAGC_GAIN_HI:`IAGC_GAIN_LO]),
	.slew_on(ramp_on[3]),
	.hold(ramp_hold[3]),
	.step_cycles(step_cyc),
	.gain_reg(amp_gain_code[23:18]),
	.busy_reg(amp_ramp_busy[3])
);

endmodule

// ### rtl/iagc_consts.vh
// constants for the input amplifier gain control register bank
`ifndef IAGC_CONSTS_VH
`define IAGC_CONSTS_VH

// register addresses on the control port
`define IAGC_ADDR_AMP0 8'h23
`define IAGC_ADDR_AMP1 8'h24
`define IAGC_ADDR_AMP2 8'h25
`define IAGC_ADDR_AMP3 8'h26
`define IAGC_ADDR_SLEW 8'h27
`define IAGC_ADDR_BOOST 8'h28

// reset values
`define IAGC_AMP_RST 8'h40
`define IAGC_SLEW_RST 8'h00
`define IAGC_BOOST_RST 8'h00

// amplifier control fields
`define IAGC_MIC_BIT 7
`define IAGC_MUTE_BIT 6
`define IAGC_GAIN_HI 5
`define IAGC_GAIN_LO 0

// slew and boost control fields
`define IAGC_RATE_HI 5
`define IAGC_RATE_LO 4
`define IAGC_RDIS_HI 3
`define IAGC_RDIS_LO 0
`define IAGC_BOOST_HI 3
`define IAGC_BOOST_LO 0

// slew rate codes
`define IAGC_RATE_FAST 2'h0
`define IAGC_RATE_MID 2'h1
`define IAGC_RATE_SLOW 2'h2
`define IAGC_RATE_RSVD 2'h3

// ramp durations in microseconds, clock in MHz
`define IAGC_RAMP_FAST_US 21500
`define IAGC_RAMP_MID_US 42500
`define IAGC_RAMP_SLOW_US 85000
`define IAGC_CLK_MHZ 250
// full scale ramp spans this many gain steps
`define IAGC_RAMP_STEPS 63

// width of the step period counter
`define IAGC_CNT_W 20

// step periods in cycles: ramp time times clock over steps, rounded down
`define IAGC_STEP_FAST_CYC 20'h1_4d45
`define IAGC_STEP_MID_CYC 20'h2_92ca
`define IAGC_STEP_SLOW_CYC 20'h5_2595

`endif

// ### rtl/iagc_ramp.v
// gain ramp for one input amplifier
`timescale 1ns/10ps
`include "iagc_consts.vh"

module iagc_ramp
(
	input wire sys_clk,
	input wire sys_rst,
	input wire [5:0] target_code,
	input wire slew_on,
	input wire hold,
	input wire [`IAGC_CNT_W-1:0] step_cycles,
	output reg [5:0] gain_reg,
	output reg busy_reg
);

reg [5:0] gain_next;
reg busy_next;
reg [`IAGC_CNT_W-1:0] cnt_reg;
reg [`IAGC_CNT_W-1:0] cnt_next;

always @*
begin
	gain_next = gain_reg;
	cnt_next = cnt_reg;
	busy_next = 1'b0;
	if (hold)
	begin
		// muted: gain code not followed
		cnt_next = {`IAGC_CNT_W{1'b0}};
	end
	else if (!slew_on)
	begin
		// snap straight to the target
		gain_next = target_code;
		cnt_next = {`IAGC_CNT_W{1'b0}};
	end
	else if (gain_reg != target_code)
	begin
		busy_next = 1'b1;
		if (cnt_reg + 1'b1 >= step_cycles)
		begin
			cnt_next = {`IAGC_CNT_W{1'b0}};
			if (gain_reg < target_code)
				gain_next = gain_reg + 6'h01;
			else
				gain_next = gain_reg - 6'h01;
		end
		else
			cnt_next = cnt_reg + 1'b1;
	end
	else
		cnt_next = {`IAGC_CNT_W{1'b0}};
end

always @(posedge sys_clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		gain_reg <= 6'h00;
		busy_reg <= 1'b0;
		cnt_reg <= {`IAGC_CNT_W{1'b0}};
	end
	else
	begin
		gain_reg <= gain_next;
		busy_reg <= busy_next;
		cnt_reg <= cnt_next;
	end
end

endmodule

// ### dv/iagc_asserts.sv
// assertions on the gain control register bank ports
`timescale 1ns/10ps
module iagc_asserts
(
	input wire sys_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid,
	input wire [3:0] amp_mic_select,
	input wire [3:0] amp_power_up,
	input wire [3:0] amp_mute,
	input wire [3:0] amp_extra_gain,
	input wire [3:0] gain_ramp_disable,
	input wire [23:0] amp_gain_code
);
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
read_valid_a: assert property (reg_rvalid == $past(reg_rd))
	else $error("rvalid");
rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
	else $error("rdata");
unmapped_read_a: assert property (reg_rd &&
	(reg_addr < 8'h23 || reg_addr > 8'h28) |=> reg_rdata == 8'h00)
	else $error("unmapped");
power_match_a: assert property (amp_power_up == amp_mic_select)
	else $error("power");
mute_freeze_a: assert property (amp_mute[0] && $past(amp_mute[0]) |->
	$stable(amp_gain_code[5:0])) else $error("mute");
amp0_write_a: assert property (reg_wr && reg_addr == 8'h23 |-> ##2
	amp_mute[0] == $past(reg_wdata[6], 2) &&
	amp_mic_select[0] == $past(reg_wdata[7], 2)) else $error("amp0");
boost_write_a: assert property (reg_wr && reg_addr == 8'h28 |-> ##2
	amp_extra_gain == $past(reg_wdata[3:0], 2)) else $error("boost");
slew_write_a: assert property (reg_wr && reg_addr == 8'h27 |-> ##2
	gain_ramp_disable == $past(reg_wdata[3:0], 2)) else $error("slew");
amp3_write_a: assert property (reg_wr && reg_addr == 8'h26 |-> ##2
	amp_power_up[3] == $past(reg_wdata[7], 2) &&
	amp_mute[3] == $past(reg_wdata[6], 2)) else $error("amp3");
endmodule
bind iagc_regs iagc_asserts u_iagc_asserts (.*);

// ### dv/iagc_regs_test.sv
// self-checking bench for the gain control register bank
`timescale 1ns/10ps
module iagc_regs_test;
reg sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
wire [7:0] reg_rdata;
wire [23:0] gain;
wire [3:0] busy;
wire rvalid;
wire [3:0] mic, pwr, mute, boost, rdis;
integer num_errors = 0, n_tests = 0, cyc = 0, i;
iagc_regs #(.RAMP_FAST_CYC(4), .RAMP_MID_CYC(8), .RAMP_SLOW_CYC(16))
	u_iagc_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(rvalid),
	.amp_mic_select(mic), .amp_power_up(pwr), .amp_mute(mute),
	.amp_extra_gain(boost), .gain_ramp_disable(rdis), .amp_gain_code(gain),
	.amp_ramp_busy(busy));
always #2 sys_clk = ~sys_clk;
always @(posedge sys_clk)
begin
	cyc <= cyc + 1;
	if (cyc == 2000)
	begin
		num_errors = num_errors + 1;
		report_and_stop;
	end
end
task report_and_stop;
begin
	$display("errors %0d checks %0d", num_errors, n_tests);
	if (num_errors == 0 && n_tests > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
end
endtask
task chk(input [7:0] got, input [7:0] exp);
begin
	n_tests = n_tests + 1;
	if (got !== exp)
	begin
		num_errors = num_errors + 1;
		$display("unexpected at %0t got %h exp %h", $time, got, exp);
	end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
	@(posedge sys_clk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge sys_clk);
	reg_wr <= 1'b0;
end
endtask
task rd(input [7:0] a, input [7:0] e);
begin
	@(posedge sys_clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge sys_clk);
	reg_rd <= 1'b0;
	#1 chk(reg_rdata, e);
	chk({7'h00, rvalid}, 8'h01);
end
endtask
task wt(input integer n);
begin
	repeat (n) @(posedge sys_clk);
	#1;
end
endtask
initial
begin
	repeat (8) @(posedge sys_clk);
	sys_rst <= 1'b0;
	for (i = 0; i < 6; i = i + 1)
		rd(8'h23 + i[7:0], i < 4 ? 8'h40 : 8'h00);
	chk({4'h0, mute}, 8'h0f);
	chk({mic, pwr}, 8'h00);
	chk({boost, rdis}, 8'h00);
	$display("reset test done");
	wr(8'h23, 8'h85);
	wt(6);
	chk({7'h00, busy[0]}, 8'h01);
	wt(40);
	chk({2'b00, gain[5:0]}, 8'h05);
	wr(8'h27, 8'h01);
	wr(8'h23, 8'h8a);
	wt(3);
	chk({2'b00, gain[5:0]}, 8'h0a);
	wr(8'h23, 8'hea);
	wt(5);
	chk({2'b00, gain[5:0]}, 8'h0a);
	wr(8'h24, 8'h07);
	wt(3);
	chk({2'b00, gain[11:6]}, 8'h07);
	chk({mic, pwr}, 8'h11);
	chk({mute, rdis}, 8'hd1);
	wr(8'h27, 8'h20);
	wr(8'h25, 8'h83);
	wt(20);
	chk({7'h00, busy[2]}, 8'h01);
	chk({2'b00, gain[17:12]}, 8'h01);
	wt(60);
	chk({2'b00, gain[17:12]}, 8'h03);
	wr(8'h27, 8'h10);
	wr(8'h26, 8'h82);
	wt(12);
	chk({2'b00, gain[23:18]}, 8'h01);
	wt(8);
	chk({2'b00, gain[23:18]}, 8'h02);
	wr(8'h27, 8'h30);
	wr(8'h26, 8'h85);
	wt(6);
	chk({2'b00, gain[23:18]}, 8'h03);
	wt(8);
	chk({2'b00, gain[23:18]}, 8'h05);
	$display("ramp test done");
	for (i = 0; i < 6; i = i + 1)
		wr(8'h23 + i[7:0], 8'hb0 + i[7:0]);
	for (i = 0; i < 6; i = i + 1)
		rd(8'h23 + i[7:0], 8'hb0 + i[7:0]);
	wr(8'h29, 8'hff);
	rd(8'h29, 8'h00);
	rd(8'h22, 8'h00);
	chk({mic, pwr}, 8'hff);
	chk({mute, rdis}, 8'h04);
	chk({4'h0, boost}, 8'h05);
	$display("access test done");
	report_and_stop;
end
endmodule
